// ===== hw/tcs_sequencer.sv
// Conversion sequencer with double-buffered results and over-temperature outputs.
// Assumes a front end on core_clk presenting the steered channel's result on meas_data_i.
//
// Function
// RULE_01: Integer results at offsets 00h and 01h, sign plus seven bits, 1 degree.
// RULE_02: Slow rates add three fraction bits at 11h and 10h, eighth degree.
// RULE_03: Each channel integrates for 62.5 ms or 125 ms depending on rate.
// RULE_04: Every sequence measures every channel, used or not, never skipping one.
// RULE_05: Sequences run repeatedly while halt is 0, or once per single-shot command.
// RULE_06: Channel order is remote 1, local, remote 1, remote 2.
// RULE_07: Busy flag is set exactly while a sequence is being performed.
// RULE_08: Readable results keep previous sequence values until the sequence ends.
// RULE_09: Each over-temperature output asserts while a result exceeds its threshold.
// RULE_10: Standby during a sequence aborts it and leaves results unchanged.
// RULE_11: Configuration bit 3 selects remote 1 or remote 2 for remote registers.
// RULE_12: Rate codes 06h and up give integer only; 05h and below add fraction.
// RULE_13: Remote diode fault loads 1000 0000 and sets the diode fault flag.
// RULE_14: At completion busy clears and all result registers update together.

`timescale 1ns/1ps

// =============================================================================
// Sequencer top
// =============================================================================
module tcs_sequencer #(
    parameter int WINDOW_FAST_CYC = tcs_pkg::WINDOW_FAST_CYC,
    parameter int WINDOW_SLOW_CYC = tcs_pkg::WINDOW_SLOW_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] cfg_byte,
    input wire logic [7:0] rate_code,
    input wire logic oneshot_cmd,
    input wire logic hw_sleep_pin_n,
    input wire logic signed [7:0] ot1_limit,
    input wire logic signed [7:0] ot2_limit,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic [1:0] meas_chan_o,
    output logic meas_active_o,
    input wire logic [10:0] meas_data_i,
    input wire logic meas_fault_i,
    output logic busy_o,
    output logic diode_fault_r1_o,
    output logic diode_fault_r2_o,
    output logic overtemp_out_one_o,
    output logic overtemp_out_one_oe,
    output logic overtemp_out_two_o,
    output logic overtemp_out_two_oe
);

    // =========================================================================
    // Declarations
    // =========================================================================
    tcs_pkg::tcs_state_t state_reg, state_next;
    logic [1:0] step_reg;
    logic sleep_n_sync, sleep;
    logic halt, halt_q_reg, abort, start_go, oneshot_pend_reg;
    logic win_start, win_done, seq_fast_reg;
    logic [10:0] work_local_reg, work_r1_reg, work_r2_reg;
    logic fault_r1_reg, fault_r2_reg;
    logic [7:0] local_int_reg, r1_int_reg, r2_int_reg;
    logic [7:0] local_frac_reg, r1_frac_reg, r2_frac_reg;
    logic ot1_hit, ot2_hit;

    // Channel visited at each step of the sequence.
    function automatic tcs_pkg::tcs_chan_t chan_of(input logic [1:0] step);
        case (step)
            2'd1: chan_of = tcs_pkg::TCS_CH_LOCAL;
            2'd3: chan_of = tcs_pkg::TCS_CH_REMOTE2;
            default: chan_of = tcs_pkg::TCS_CH_REMOTE1; // [RULE_06]
        endcase
    endfunction

    // Integer byte from a result, forced to the fault code on a diode fault.
    function automatic logic [7:0] int_of(input logic [10:0] res, input logic flt);
        int_of = flt ? tcs_pkg::DIODE_FAULT_CODE : res[10:3]; // [RULE_01] [RULE_13]
    endfunction

    // Fraction byte, left aligned, zero at fast rates or on a fault.
    function automatic logic [7:0] frac_of(input logic [10:0] res, input logic flt,
                                           input logic fast);
        frac_of = (fast || flt) ? 8'h00 :
                  {res[tcs_pkg::FRAC_W-1:0], 5'h00}; // [RULE_02] [RULE_12]
    endfunction

    // True when a signed result exceeds the limit.
    function automatic logic above(input logic [7:0] val, input logic signed [7:0] lim);
        above = ($signed(val) > lim);
    endfunction

    // =========================================================================
    // Standby, halt and start control
    // =========================================================================
    tcs_sync2 #(
        .RESET_VAL(1'b1)
    ) u_sleep_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(hw_sleep_pin_n),
        .sync_out(sleep_n_sync)
    );

    // Hardware standby is the pin held low; a rising halt bit is software standby.
    assign sleep = ~sleep_n_sync;
    assign halt = cfg_byte[tcs_pkg::CFG_HALT_BIT];
    assign abort = (state_reg == tcs_pkg::TCS_MEASURE) && (sleep || (halt && !halt_q_reg));
    assign start_go = !sleep && (!halt || oneshot_pend_reg); // [RULE_05]

    // Remembers a single-shot command until a sequence takes it; a new command wins.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oneshot_pend_reg <= 1'b0;
            halt_q_reg <= 1'b0;
        end else begin
            halt_q_reg <= halt;
            if (oneshot_cmd && !sleep) begin
                oneshot_pend_reg <= 1'b1; // [RULE_05]
            end else if (state_reg == tcs_pkg::TCS_IDLE && start_go) begin
                oneshot_pend_reg <= 1'b0;
            end
        end
    end

    // =========================================================================
    // Sequence state machine
    // =========================================================================
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tcs_pkg::TCS_IDLE: begin
                if (start_go) begin
                    state_next = tcs_pkg::TCS_MEASURE;
                end
            end
            tcs_pkg::TCS_MEASURE: begin
                if (abort) begin
                    state_next = tcs_pkg::TCS_IDLE; // [RULE_10]
                end else if (win_done && step_reg == 2'd3) begin
                    state_next = tcs_pkg::TCS_COMMIT; // [RULE_04]
                end
            end
            tcs_pkg::TCS_COMMIT: begin
                state_next = tcs_pkg::TCS_IDLE;
            end
            default: begin
                state_next = tcs_pkg::TCS_IDLE;
            end
        endcase
    end

    // Starts a window on entry and on every step except the last.
    assign win_start = (state_reg == tcs_pkg::TCS_IDLE && start_go) ||
                       (state_reg == tcs_pkg::TCS_MEASURE && win_done && !abort &&
                        step_reg != 2'd3);

    // Holds state, step, rate choice and the multiplexer outputs.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= tcs_pkg::TCS_IDLE;
            step_reg <= 2'd0;
            seq_fast_reg <= 1'b0;
            meas_chan_o <= 2'(tcs_pkg::TCS_CH_REMOTE1);
            meas_active_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            meas_active_o <= (state_next == tcs_pkg::TCS_MEASURE);
            busy_o <= (state_next != tcs_pkg::TCS_IDLE); // [RULE_07] [RULE_14]
            if (state_reg == tcs_pkg::TCS_IDLE && start_go) begin
                step_reg <= 2'd0;
                seq_fast_reg <= (rate_code >= tcs_pkg::RATE_FAST_MIN); // [RULE_12]
                meas_chan_o <= 2'(chan_of(2'd0));
            end else if (win_start) begin
                step_reg <= step_reg + 2'd1; // [RULE_04] [RULE_06]
                meas_chan_o <= 2'(chan_of(step_reg + 2'd1));
            end
        end
    end

    tcs_window_timer #(
        .FAST_CYC(WINDOW_FAST_CYC),
        .SLOW_CYC(WINDOW_SLOW_CYC),
        .CNT_W(24)
    ) u_window (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(win_start),
        .long_sel(state_reg == tcs_pkg::TCS_IDLE ? (rate_code < tcs_pkg::RATE_FAST_MIN)
                                                  : !seq_fast_reg), // [RULE_03]
        .abort(abort),
        .done(win_done)
    );

    // =========================================================================
    // Working and readable results
    // =========================================================================
    // Captures each window's result into the working set, invisible to reads.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            work_local_reg <= '0;
            work_r1_reg <= '0;
            work_r2_reg <= '0;
            fault_r1_reg <= 1'b0;
            fault_r2_reg <= 1'b0;
        end else if (state_reg == tcs_pkg::TCS_MEASURE && win_done && !abort) begin
            case (chan_of(step_reg))
                tcs_pkg::TCS_CH_LOCAL: begin
                    work_local_reg <= meas_data_i;
                end
                tcs_pkg::TCS_CH_REMOTE1: begin
                    work_r1_reg <= meas_data_i;
                    fault_r1_reg <= meas_fault_i; // [RULE_13]
                end
                default: begin
                    work_r2_reg <= meas_data_i;
                    fault_r2_reg <= meas_fault_i; // [RULE_13]
                end
            endcase
        end
    end

    // Copies the whole working set in one cycle at completion only.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            local_int_reg <= tcs_pkg::RESULT_RESET;
            r1_int_reg <= tcs_pkg::RESULT_RESET;
            r2_int_reg <= tcs_pkg::RESULT_RESET;
            local_frac_reg <= tcs_pkg::RESULT_RESET;
            r1_frac_reg <= tcs_pkg::RESULT_RESET;
            r2_frac_reg <= tcs_pkg::RESULT_RESET;
            diode_fault_r1_o <= 1'b0;
            diode_fault_r2_o <= 1'b0;
        end else if (state_reg == tcs_pkg::TCS_COMMIT) begin
            local_int_reg <= int_of(work_local_reg, 1'b0); // [RULE_08] [RULE_14]
            r1_int_reg <= int_of(work_r1_reg, fault_r1_reg);
            r2_int_reg <= int_of(work_r2_reg, fault_r2_reg);
            local_frac_reg <= frac_of(work_local_reg, 1'b0, seq_fast_reg);
            r1_frac_reg <= frac_of(work_r1_reg, fault_r1_reg, seq_fast_reg);
            r2_frac_reg <= frac_of(work_r2_reg, fault_r2_reg, seq_fast_reg);
            diode_fault_r1_o <= fault_r1_reg; // [RULE_13]
            diode_fault_r2_o <= fault_r2_reg;
        end
    end

    // =========================================================================
    // Read port and over-temperature outputs
    // =========================================================================
    // Answers a read one cycle later; the remote offsets follow the select bit.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rd_data <= tcs_pkg::UNMAPPED_READ;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                case (reg_addr)
                    tcs_pkg::OFS_LOCAL_INT: reg_rd_data <= local_int_reg; // [RULE_01]
                    tcs_pkg::OFS_REMOTE_INT: reg_rd_data <=
                        cfg_byte[tcs_pkg::CFG_REMOTE_SEL_BIT] ? r2_int_reg : r1_int_reg; // [RULE_11]
                    tcs_pkg::OFS_LOCAL_FRAC: reg_rd_data <= local_frac_reg; // [RULE_02]
                    tcs_pkg::OFS_REMOTE_FRAC: reg_rd_data <=
                        cfg_byte[tcs_pkg::CFG_REMOTE_SEL_BIT] ? r2_frac_reg : r1_frac_reg; // [RULE_11]
                    default: reg_rd_data <= tcs_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    // Fault codes are excluded so a broken diode does not look cold or hot.
    assign ot1_hit = above(local_int_reg, ot1_limit) ||
                     (!diode_fault_r1_o && above(r1_int_reg, ot1_limit)) ||
                     (!diode_fault_r2_o && above(r2_int_reg, ot1_limit));
    assign ot2_hit = above(local_int_reg, ot2_limit) ||
                     (!diode_fault_r1_o && above(r1_int_reg, ot2_limit)) ||
                     (!diode_fault_r2_o && above(r2_int_reg, ot2_limit));

    // Open-drain outputs pull low while the temperature is above the limit.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overtemp_out_one_o <= 1'b0;
            overtemp_out_two_o <= 1'b0;
            overtemp_out_one_oe <= 1'b0;
            overtemp_out_two_oe <= 1'b0;
        end else begin
            overtemp_out_one_o <= 1'b0;
            overtemp_out_two_o <= 1'b0;
            overtemp_out_one_oe <= ot1_hit; // [RULE_09]
            overtemp_out_two_oe <= ot2_hit; // [RULE_09]
        end
    end

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_commit;
        state_reg == tcs_pkg::TCS_COMMIT;
    endsequence

    sequence s_last_done;
        state_reg == tcs_pkg::TCS_MEASURE && win_done && !abort && step_reg == 2'd3;
    endsequence

    AST_BUSY_IDLE: assert property ( // [RULE_07]
        state_reg == tcs_pkg::TCS_IDLE && !start_go |=> !busy_o)
        else $error("busy set while idle");
    AST_AUTO_START: assert property ( // [RULE_05]
        state_reg == tcs_pkg::TCS_IDLE && !halt && !sleep |=> busy_o && step_reg == 2'd0)
        else $error("free-running start missed");
    AST_HOLD: assert property ( // [RULE_08]
        state_reg == tcs_pkg::TCS_MEASURE |=> $stable(local_int_reg) && $stable(r1_int_reg))
        else $error("results changed during a sequence");
    AST_COMMIT: assert property ( // [RULE_14]
        s_last_done ##1 s_commit |-> busy_o ##1
        (!busy_o && local_int_reg == $past(work_local_reg[10:3])))
        else $error("commit did not update together");
    AST_ORDER: assert property ( // [RULE_06]
        state_reg == tcs_pkg::TCS_MEASURE && step_reg == 2'd1 |-> meas_chan_o ==
        2'(tcs_pkg::TCS_CH_LOCAL))
        else $error("local not second in order");
    AST_ALL_CH: assert property ( // [RULE_04]
        state_reg == tcs_pkg::TCS_MEASURE && state_next == tcs_pkg::TCS_COMMIT |->
        step_reg == 2'd3)
        else $error("sequence ended before all channels");
    AST_FAULT: assert property ( // [RULE_13]
        s_commit and fault_r1_reg |=> r1_int_reg == 8'h80 && diode_fault_r1_o)
        else $error("diode fault code not loaded");
    AST_FAST_INT: assert property ( // [RULE_12]
        s_commit and seq_fast_reg |=> local_frac_reg == 8'h00 && r2_frac_reg == 8'h00)
        else $error("fraction present at fast rate");
    AST_OT: assert property ( // [RULE_09]
        ##1 overtemp_out_one_oe == $past(ot1_hit) && overtemp_out_two_oe == $past(ot2_hit))
        else $error("over-temperature output wrong");
    AST_ABORT: assert property ( // [RULE_10]
        abort |=> state_reg == tcs_pkg::TCS_IDLE ##1 $stable(local_int_reg)[*2])
        else $error("abort did not hold results");

endmodule // tcs_sequencer

// ===== hw/tcs_pkg.sv
// Package of constants shared by the temperature conversion sequencer files.
// Assumes a 100 MHz core clock and a result read port addressed by 8-bit offsets.

// =============================================================================
// Package
// =============================================================================
package tcs_pkg;

    // Clock period of core_clk in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;

    // Integration windows in microseconds and their cycle counts.
    localparam int WINDOW_FAST_US = 62500;
    localparam int WINDOW_SLOW_US = 125000;
    localparam int WINDOW_FAST_CYC = (WINDOW_FAST_US * 1000) / CLK_PERIOD_NS;
    localparam int WINDOW_SLOW_CYC = (WINDOW_SLOW_US * 1000) / CLK_PERIOD_NS;

    // Register offsets of the result read port.
    localparam logic [7:0] OFS_LOCAL_INT = 8'h00;
    localparam logic [7:0] OFS_REMOTE_INT = 8'h01;
    localparam logic [7:0] OFS_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] OFS_LOCAL_FRAC = 8'h11;

    // Configuration byte fields.
    localparam int CFG_HALT_BIT = 6;
    localparam int CFG_REMOTE_SEL_BIT = 3;

    // Lowest rate code that gives integer-only results.
    localparam logic [7:0] RATE_FAST_MIN = 8'h06;

    // Result layout: sign plus seven integer bits, then three fraction bits.
    localparam int RES_W = 11;
    localparam int FRAC_W = 3;
    localparam int FRAC_POS = 5;

    // Reset and fault patterns.
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] DIODE_FAULT_CODE = 8'h80;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Channels the multiplexer can steer to.
    typedef enum logic [1:0] {
        TCS_CH_LOCAL,
        TCS_CH_REMOTE1,
        TCS_CH_REMOTE2
    } tcs_chan_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        TCS_IDLE,
        TCS_MEASURE,
        TCS_COMMIT
    } tcs_state_t;

endpackage

// ===== hw/tcs_sync2.sv
// Two flip-flop synchroniser for one level from a pin.
// Assumes the input is asynchronous to core_clk.

`timescale 1ns/1ps

// =============================================================================
// Synchroniser
// =============================================================================
module tcs_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_reg;

    // Only the second stage is read outside this module.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // tcs_sync2

// ===== hw/tcs_window_timer.sv
// Integration window timer: one start pulse gives one done pulse after the window.
// Assumes start and abort come from logic on core_clk.

`timescale 1ns/1ps

// =============================================================================
// Window timer
// =============================================================================
module tcs_window_timer #(
    parameter int FAST_CYC = 6250000,
    parameter int SLOW_CYC = 12500000,
    parameter int CNT_W = 24
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic long_sel,
    input wire logic abort,
    output logic done
);

    // Refuse counts that the counter cannot hold.
    if (FAST_CYC < 2 || SLOW_CYC < 2 || SLOW_CYC >= (64'd1 << CNT_W)) begin : g_bad
        $error("tcs_window_timer: window counts do not fit the counter");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic run_reg;

    // Counts down from the selected window length and pulses done at the end.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else if (abort) begin
            run_reg <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt_reg <= long_sel ? CNT_W'(SLOW_CYC - 2) : CNT_W'(FAST_CYC - 2);
            run_reg <= 1'b1;
            done <= 1'b0;
        end else if (run_reg) begin
            done <= (cnt_reg == '0);
            run_reg <= (cnt_reg != '0);
            cnt_reg <= cnt_reg - CNT_W'(1);
        end else begin
            done <= 1'b0;
        end
    end

endmodule // tcs_window_timer

// ===== tb/tcs_fe_model.sv
// Behavioural front end that answers the steered channel with a set value.
// Assumes the sequencer samples the data in the cycle its window ends.
`timescale 1ns/1ps
// =============================================================================
// Front end model
// =============================================================================
module tcs_fe_model (
    input wire logic [1:0] meas_chan_o,
    input wire logic meas_active_o,
    input wire logic [10:0] local_val,
    input wire logic [10:0] r1_val,
    input wire logic [10:0] r2_val,
    input wire logic r2_fault,
    output logic [10:0] meas_data_i,
    output logic meas_fault_i
);
    logic [10:0] v;
    // Outside a window the data shows the inverse, so a stray sample is wrong.
    always_comb begin
        v = (meas_chan_o == 2'd0) ? local_val : (meas_chan_o == 2'd1) ? r1_val : r2_val;
        meas_data_i = (meas_active_o && meas_chan_o != 2'd3) ? v : ~v;
        meas_fault_i = meas_active_o && r2_fault && meas_chan_o == 2'd2;
    end
endmodule // tcs_fe_model

// ===== tb/tb_top.sv
// Self-checking bench of the conversion sequencer with a front end model.
// Assumes short integration windows set through the top parameters.
`timescale 1ns/1ps
// =============================================================================
// Bench top
// =============================================================================
module tb_top;
    localparam logic [1:0] ORD [4] = '{2'd1, 2'd0, 2'd1, 2'd2};
    localparam int WF = 20;
    localparam int WS = 40;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cfg_byte = 8'h40;
    logic [7:0] rate_code = 8'h05;
    logic oneshot_cmd = 1'b0;
    logic hw_sleep_pin_n = 1'b1;
    logic signed [7:0] ot1_limit = 8'sh50;
    logic signed [7:0] ot2_limit = 8'sh60;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid, meas_active_o, meas_fault_i, busy_o, f1, f2, o1, o2, e1, e2;
    logic [1:0] meas_chan_o;
    logic [10:0] meas_data_i;
    logic [10:0] lv = 11'h0cd;
    logic [10:0] r1 = 11'h2a3;
    logic [10:0] r2 = 11'h7f9;
    logic r2f = 1'b0;
    int error_cnt = 0;
    int checks_done = 0;
    logic [1:0] order_q [$];
    logic act_d = 1'b0;
    logic [1:0] chan_d = 2'd0;
    tcs_sequencer #(.WINDOW_FAST_CYC(WF), .WINDOW_SLOW_CYC(WS)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .cfg_byte(cfg_byte), .rate_code(rate_code),
        .oneshot_cmd(oneshot_cmd), .hw_sleep_pin_n(hw_sleep_pin_n), .ot1_limit(ot1_limit),
        .ot2_limit(ot2_limit), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .meas_chan_o(meas_chan_o),
        .meas_active_o(meas_active_o), .meas_data_i(meas_data_i),
        .meas_fault_i(meas_fault_i), .busy_o(busy_o), .diode_fault_r1_o(f1),
        .diode_fault_r2_o(f2), .overtemp_out_one_o(o1), .overtemp_out_one_oe(e1),
        .overtemp_out_two_o(o2), .overtemp_out_two_oe(e2));
    tcs_fe_model fe (.meas_chan_o(meas_chan_o), .meas_active_o(meas_active_o),
        .local_val(lv), .r1_val(r1), .r2_val(r2), .r2_fault(r2f),
        .meas_data_i(meas_data_i), .meas_fault_i(meas_fault_i));
    // Clock of 100 MHz.
    always #5 core_clk = ~core_clk;
    // Records each channel step while a window runs.
    always @(posedge core_clk) begin
        if (meas_active_o === 1'b1 && (act_d !== 1'b1 || chan_d !== meas_chan_o)) begin
            order_q.push_back(meas_chan_o);
        end
        act_d <= meas_active_o;
        chan_d <= meas_chan_o;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Reads one offset; the answer stands for the one cycle after the strobe edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge core_clk) #1 reg_rd_en = 1'b0;
        chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
        chk($sformatf("rd_%h", a), exp, reg_rd_data);
        @(posedge core_clk) #1 chk("rd_valid_end", 8'h00, {7'h00, reg_rd_valid});
    endtask
    // Waits for busy to rise and then to fall; a nonzero length is checked too.
    task automatic wait_seq(input int exp_len);
        int n;
        n = 0;
        while (busy_o !== 1'b1 && n < 20) begin @(posedge core_clk) #1 n++; end
        chk("busy_rise", 8'h01, {7'h00, busy_o});
        n = 0;
        while (busy_o !== 1'b0 && n < 400) begin @(posedge core_clk) #1 n++; end
        chk("busy_fall", 8'h00, {7'h00, busy_o});
        if (exp_len > 0) chk("seq_len", 8'(exp_len), 8'(n));
    endtask
    task automatic shot();
        oneshot_cmd = 1'b1;
        @(posedge core_clk) #1 oneshot_cmd = 1'b0;
    endtask
    // Single shot in software standby at a slow rate, then every offset.
    task automatic t_slow();
        order_q.delete();
        shot();
        repeat (100) @(posedge core_clk);
        #1 rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        wait_seq(0);
        chk("order_len", 8'h04, 8'(order_q.size()));
        for (int i = 0; i < 4; i++) chk("order", {6'h0, ORD[i]}, {6'h0, order_q[i]});
        rd(8'h00, lv[10:3]);
        rd(8'h11, {lv[2:0], 5'h00});
        rd(8'h01, r1[10:3]);
        rd(8'h10, {r1[2:0], 5'h00});
        cfg_byte = 8'h48;
        rd(8'h01, r2[10:3]);
        rd(8'h10, {r2[2:0], 5'h00});
        rd(8'h05, 8'h00);
        chk("ot1", 8'h01, {7'h00, e1});
        chk("ot2", 8'h00, {7'h00, e2});
        chk("ot_data", 8'h00, {6'h00, o1, o2});
    endtask
    // Free run at the fast rate, then halt aborts the next sequence.
    task automatic t_fast();
        rate_code = 8'h06;
        r2f = 1'b1;
        cfg_byte = 8'h08;
        wait_seq(4 * WF + 1);
        rd(8'h11, 8'h00);
        rd(8'h01, 8'h80);
        rd(8'h10, 8'h00);
        chk("fault_r2", 8'h01, {7'h00, f2});
        chk("fault_r1", 8'h00, {7'h00, f1});
        lv = 11'h100;
        repeat (10) @(posedge core_clk);
        #1 cfg_byte = 8'h48;
        repeat (3) @(posedge core_clk);
        #1 chk("abort_busy", 8'h00, {7'h00, busy_o});
        repeat (100) @(posedge core_clk);
        #1 rd(8'h00, 8'h19);
    endtask
    // A single shot under the hardware sleep pin is ignored.
    task automatic t_sleep();
        hw_sleep_pin_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 shot();
        repeat (10) @(posedge core_clk);
        #1 chk("sleep_busy", 8'h00, {7'h00, busy_o});
        hw_sleep_pin_n = 1'b1;
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (16) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h11, 8'h00);
        t_slow();
        t_fast();
        t_sleep();
        finish_test();
    end
    // Watchdog cuts a hang short.
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule // tb_top
